// file: acl_defines.svh
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH
`define ACL_NENT 16
`define ACL_NPORT 5
`define ACL_TBL_BASE 8'h00
`define ACL_PCTL_BASE 8'h40
`define ACL_STAT 8'h48
`define ACL_TBL_RST 32'h00000000
`define ACL_PCTL_RST 3'h0
`define ACL_F_MODE 0
`define ACL_F_TSEL 2
`define ACL_F_SD 4
`define ACL_F_EQ 5
`define ACL_F_PC 6
`define ACL_F_FME 8
`define ACL_F_CNT 9
`define ACL_F_MM 9
`define ACL_F_RP 11
`define ACL_F_RPE 14
`define ACL_F_P 15
`define ACL_F_PM 18
`define ACL_F_FWD 20
`define ACL_F_UNIT 24
`define ACL_F_ALGO 23
`define ACL_F_PROTO 0
`define ACL_F_FLAG 8
`define ACL_F_TCP_FLAG_MASK 16
`define ACL_F_TYPE 16
`define ACL_F_FRN 0
`define ACL_F_GRP 16
`define ACL_CPU_MAP 5'h10
`define ACL_CLK_NS 10
`define ACL_US_NS 1000
`define ACL_MS_US 1000
`define ACL_US_CYC (`ACL_US_NS / `ACL_CLK_NS)
`endif

// file: acl_frame_model.sv
`timescale 1ns/1ns
`default_nettype none
module acl_frame_model (
   // Clock
   input wire logic clk_in,
   // Frame towards the engine
   output logic frm_valid_out,
   output logic [2:0] frm_port_out,
   output logic [47:0] frm_src_mac_out,
   output logic [47:0] frm_dst_mac_out,
   output logic [15:0] frm_type_out,
   output logic [31:0] frm_src_ip_out,
   output logic [31:0] frm_dst_ip_out,
   output logic [7:0] frm_ip_proto_out,
   output logic frm_is_tcp_out,
   output logic frm_is_udp_out,
   output logic [15:0] frm_src_l4_out,
   output logic [15:0] frm_dst_l4_out,
   output logic [31:0] frm_tcp_seq_out,
   output logic [5:0] frm_tcp_flags_out,
   output logic frm_tagged_out,
   output logic [2:0] frm_vlan_prio_out,
   output logic [4:0] lut_map_out,
   output logic [2:0] qos_prio_out
);
   logic [270:0] f;
   assign {frm_port_out, frm_src_mac_out, frm_dst_mac_out, frm_type_out,
      frm_src_ip_out, frm_dst_ip_out, frm_ip_proto_out, frm_is_tcp_out,
      frm_is_udp_out, frm_src_l4_out, frm_dst_l4_out, frm_tcp_seq_out,
      frm_tcp_flags_out, frm_tagged_out, frm_vlan_prio_out, lut_map_out,
      qos_prio_out} = f;
   initial begin
      frm_valid_out = 1'b0;
      f = '0;
   end
   // One parsed frame; fields go stale (inverted) after the valid cycle
   task send(input logic [2:0] p, input logic [47:0] sm, dm,
      input logic [15:0] ty, input logic [31:0] si, di,
      input logic [4:0] lut, input logic [2:0] q);
      @(posedge clk_in);
      f <= {p, sm, dm, ty, si, di, 8'h06, 1'b1, 1'b0, 16'h0050, 16'h1F90,
         32'h00000000, 6'h12, 1'b1, 3'h1, lut, q};
      frm_valid_out <= 1'b1;
      @(posedge clk_in);
      frm_valid_out <= 1'b0;
      f <= ~f;
   endtask
endmodule
`default_nettype wire

// file: acl_pkg.sv
`default_nettype none
`include "acl_defines.svh"
package acl_pkg;
   typedef enum logic [1:0] {
      ACL_OFF = 2'h0,
      ACL_L2 = 2'h1,
      ACL_L3 = 2'h2,
      ACL_L4 = 2'h3
   } acl_mode_t;
   typedef struct packed {
      logic [`ACL_NENT-1:0][3:0][31:0] tbl;
      logic [`ACL_NPORT-1:0][2:0] pctl;
      logic [`ACL_NENT-1:0][10:0] cnt;
      logic [`ACL_NENT-1:0] armed;
      logic [`ACL_NENT-1:0] alarm;
      logic [9:0] pre;
      logic [9:0] msc;
      logic [31:0] rdata;
      logic res_v;
      logic [4:0] map;
      logic [2:0] prio;
      logic [2:0] vlan;
      logic drop;
      logic hit;
      logic [3:0] win;
   } acl_state_t;
endpackage
`default_nettype wire

// file: acl_rule_filter_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "acl_defines.svh"
module acl_rule_filter_engine
   import acl_pkg::*;
#(
   parameter int US_CYC = `ACL_US_CYC,
   parameter int MS_US = `ACL_MS_US
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Parsed frame
   input wire logic frm_valid_in,
   input wire logic [2:0] frm_port_in,
   input wire logic [47:0] frm_src_mac_in,
   input wire logic [47:0] frm_dst_mac_in,
   input wire logic [15:0] frm_type_in,
   input wire logic [31:0] frm_src_ip_in,
   input wire logic [31:0] frm_dst_ip_in,
   input wire logic [7:0] frm_ip_proto_in,
   input wire logic frm_is_tcp_in,
   input wire logic frm_is_udp_in,
   input wire logic [15:0] frm_src_l4_in,
   input wire logic [15:0] frm_dst_l4_in,
   input wire logic [31:0] frm_tcp_seq_in,
   input wire logic [5:0] frm_tcp_flags_in,
   input wire logic frm_tagged_in,
   input wire logic [2:0] frm_vlan_prio_in,
   input wire logic [4:0] lut_map_in,
   input wire logic [2:0] qos_prio_in,
   // Result
   output logic res_valid_out,
   output logic [4:0] res_map_out,
   output logic [2:0] res_prio_out,
   output logic [2:0] res_vlan_prio_out,
   output logic res_drop_out,
   output logic res_hit_out,
   output logic [3:0] res_rule_out,
   // Timing counter events
   output logic [`ACL_NENT-1:0] count_alarm_out
);
   acl_state_t s;
   acl_state_t n;
   logic [`ACL_NENT-1:0] ent_hit;
   logic [`ACL_NENT-1:0] cnt_hit;
   logic [`ACL_NENT-1:0] set_ok;
   logic [`ACL_NENT-1:0] frn_hit;
   logic [`ACL_NENT-1:0] mode_on;
   logic any_hit;
   logic [3:0] win;
   logic us_t;
   logic ms_t;
   logic pc_en_now;

   // ----------------------------------------
   // Per-entry matching
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `ACL_NENT; gi = gi + 1) begin : g_ent
         logic [31:0] w0;
         logic [31:0] w1;
         logic [31:0] w2;
         logic [15:0] grp;
         acl_mode_t md;
         logic [1:0] ts;
         logic sd;
         logic [47:0] mac;
         logic [31:0] ip;
         logic [15:0] l4;
         logic [15:0] pmax;
         logic [15:0] pmin;
         logic mac_eq;
         logic typ_eq;
         logic port_ok;
         logic flag_ok;
         logic cmp;
         logic qual;
         assign w0 = s.tbl[gi][0];
         assign w1 = s.tbl[gi][1];
         assign w2 = s.tbl[gi][2];
         assign grp = s.tbl[gi][3][`ACL_F_GRP +: 16];
         assign md = acl_mode_t'(w0[`ACL_F_MODE +: 2]);
         assign ts = w0[`ACL_F_TSEL +: 2];
         assign sd = w0[`ACL_F_SD];
         assign pmax = w1[31:16];
         assign pmin = w1[15:0];
         // Direction select
         assign mac = sd ? frm_src_mac_in : frm_dst_mac_in;
         assign ip = sd ? frm_src_ip_in : frm_dst_ip_in;
         assign l4 = sd ? frm_src_l4_in : frm_dst_l4_in;
         assign mac_eq = mac == {w2[15:0], w1};
         assign typ_eq = frm_type_in == w2[`ACL_F_TYPE +: 16];
         always_comb begin
            case (w0[`ACL_F_PC +: 2])
               2'h0: port_ok = 1'b1;
               2'h1: port_ok = (l4 == pmax) || (l4 == pmin);
               2'h2: port_ok = (l4 >= pmin) && (l4 <= pmax);
               default: port_ok = (l4 < pmin) || (l4 > pmax);
            endcase
         end
         // Masked flag
         assign flag_ok = !w0[`ACL_F_FME] ||
            ((frm_tcp_flags_in & w2[`ACL_F_TCP_FLAG_MASK +: 6]) ==
             (w2[`ACL_F_FLAG +: 6] & w2[`ACL_F_TCP_FLAG_MASK +: 6]));
         always_comb begin
            cmp = 1'b0;
            qual = 1'b0;
            case (md)
               ACL_L2: begin
                  qual = 1'b1;
                  case (ts)
                     2'h1: cmp = mac_eq;
                     2'h2: cmp = typ_eq;
                     default: cmp = mac_eq && typ_eq;
                  endcase
               end
               ACL_L3: begin
                  qual = ts == 2'h1 || ts == 2'h2;
                  if (ts == 2'h1) begin
                     cmp = (ip & w2) == (w1 & w2);
                  end else begin
                     cmp = frm_src_ip_in == frm_dst_ip_in;
                  end
               end
               ACL_L4: begin
                  case (ts)
                     2'h0: begin
                        qual = 1'b1;
                        cmp = frm_ip_proto_in == w2[`ACL_F_PROTO +: 8];
                     end
                     2'h1: begin
                        qual = frm_is_tcp_in;
                        cmp = port_ok && flag_ok;
                     end
                     2'h2: begin
                        qual = frm_is_udp_in;
                        cmp = port_ok;
                     end
                     default: begin
                        qual = frm_is_tcp_in;
                        cmp = (frm_tcp_seq_in == w1) && flag_ok;
                     end
                  endcase
               end
               default: begin
                  qual = 1'b0;
                  cmp = 1'b0;
               end
            endcase
         end
         assign mode_on[gi] = md != ACL_OFF;
         // Equal bit picks sense
         assign ent_hit[gi] = qual && (w0[`ACL_F_EQ] ? cmp : !cmp);
         // Count mode sees address and type
         assign cnt_hit[gi] = frm_valid_in && md == ACL_L2 &&
            ts == 2'h0 && mac_eq && typ_eq;
         // Set matches when all members hit
         assign set_ok[gi] = (grp != 16'h0000) &&
            ((ent_hit & grp) == grp);
      end
   endgenerate

   // ----------------------------------------
   // Set arbitration
   // ----------------------------------------
   always_comb begin
      frn_hit = '0;
      for (int i = 0; i < `ACL_NENT; i++) begin
         if (set_ok[i]) begin
            frn_hit[s.tbl[i][3][`ACL_F_FRN +: 4]] = 1'b1;
         end
      end
   end

   always_comb begin
      win = 4'h0;
      any_hit = |frn_hit;
      for (int i = `ACL_NENT - 1; i >= 0; i--) begin
         if (frn_hit[i]) begin
            win = 4'(i);
         end
      end
   end

   assign us_t = s.pre == 10'(US_CYC - 1);
   assign ms_t = us_t && s.msc == 10'(MS_US - 1);
   assign pc_en_now = frm_port_in < 3'h5 && s.pctl[frm_port_in][2];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [2:0] pidx;
      logic [2:0] pc;
      logic en;
      logic [31:0] aw;
      logic act;
      logic [2:0] rp;
      logic [4:0] fw;
      logic [10:0] val;
      logic tk;
      pidx = frm_port_in;
      pc = '0;
      en = 1'b0;
      aw = s.tbl[win][0];
      act = 1'b0;
      rp = '0;
      fw = '0;
      val = '0;
      tk = 1'b0;
      n = s;
      n.alarm = '0;
      n.res_v = 1'b0;
      n.rdata = '0;
      // Register writes
      if (reg_wr_in) begin
         if (reg_addr_in < `ACL_PCTL_BASE) begin
            n.tbl[reg_addr_in[5:2]][reg_addr_in[1:0]] = reg_wdata_in;
         end else if (reg_addr_in < `ACL_PCTL_BASE + 8'h05) begin
            n.pctl[reg_addr_in[2:0]] = reg_wdata_in[2:0];
         end
      end
      // Register reads
      if (reg_rd_in) begin
         if (reg_addr_in < `ACL_PCTL_BASE) begin
            n.rdata = s.tbl[reg_addr_in[5:2]][reg_addr_in[1:0]];
         end else if (reg_addr_in < `ACL_PCTL_BASE + 8'h05) begin
            n.rdata = {29'h0, s.pctl[reg_addr_in[2:0]]};
         end else if (reg_addr_in == `ACL_STAT) begin
            n.rdata = {s.armed, 8'h00, s.hit, 3'h0, s.win};
         end
      end
      // Time base
      n.pre = us_t ? 10'h000 : s.pre + 10'h001;
      if (us_t) begin
         n.msc = ms_t ? 10'h000 : s.msc + 10'h001;
      end
      // Timing counters
      for (int i = 0; i < `ACL_NENT; i++) begin
         val = s.tbl[i][0][`ACL_F_CNT +: 11];
         tk = s.tbl[i][0][`ACL_F_UNIT] ? ms_t : us_t;
         if (s.tbl[i][0][3:0] != 4'h1) begin
            n.cnt[i] = '0;
            n.armed[i] = 1'b0;
         end else if (!s.tbl[i][0][`ACL_F_ALGO]) begin
            if (cnt_hit[i]) begin
               n.cnt[i] = val;
               n.armed[i] = val != 11'h000;
            end else if (tk && s.armed[i]) begin
               if (s.cnt[i] <= 11'h001) begin
                  n.alarm[i] = 1'b1;
                  n.armed[i] = 1'b0;
                  n.cnt[i] = '0;
               end else begin
                  n.cnt[i] = s.cnt[i] - 11'h001;
               end
            end
         end else if (cnt_hit[i]) begin
            if (s.cnt[i] + 11'h001 == val) begin
               n.alarm[i] = 1'b1;
               n.cnt[i] = '0;
            end else begin
               n.cnt[i] = s.cnt[i] + 11'h001;
            end
         end
      end
      // Frame result
      if (frm_valid_in) begin
         if (pidx < 3'h5) begin
            pc = s.pctl[pidx];
         end
         en = pc[2] && any_hit;
         act = en && aw[3:0] != 4'h1;
         rp = aw[`ACL_F_P +: 3];
         fw = aw[`ACL_F_FWD +: 5];
         n.res_v = 1'b1;
         n.hit = en;
         n.win = win;
         n.map = lut_map_in;
         n.prio = qos_prio_in;
         n.vlan = frm_vlan_prio_in;
         n.drop = pc[1:0] == 2'h1 && !en;
         if (pc[1:0] == 2'h3 && !en) begin
            n.map = `ACL_CPU_MAP;
         end
         if (act) begin
            case (aw[`ACL_F_MM +: 2])
               2'h1: n.map = lut_map_in | fw;
               2'h2: n.map = lut_map_in & fw;
               2'h3: n.map = fw;
               default: n.map = lut_map_in;
            endcase
            case (aw[`ACL_F_PM +: 2])
               2'h1: n.prio = rp > qos_prio_in ? rp : qos_prio_in;
               2'h2: n.prio = rp < qos_prio_in ? rp : qos_prio_in;
               2'h3: n.prio = rp;
               default: n.prio = qos_prio_in;
            endcase
            if (aw[`ACL_F_RPE] && frm_tagged_in) begin
               n.vlan = aw[`ACL_F_RP +: 3];
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata_out = s.rdata;
   assign res_valid_out = s.res_v;
   assign res_map_out = s.map;
   assign res_prio_out = s.prio;
   assign res_vlan_prio_out = s.vlan;
   assign res_drop_out = s.drop;
   assign res_hit_out = s.hit;
   assign res_rule_out = s.win;
   assign count_alarm_out = s.alarm;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_off;
      (ent_hit & ~mode_on) == '0;
   endproperty
   a_off: assert property (p_off) else $error("disabled entry hit");

   property p_win;
      any_hit |-> (frn_hit & ((16'h0001 << win) - 16'h0001)) == '0;
   endproperty
   a_win: assert property (p_win) else $error("not lowest rule");

   property p_miss;
      frm_valid_in && !(pc_en_now && any_hit) |=>
         res_prio_out == $past(qos_prio_in);
   endproperty
   a_miss: assert property (p_miss) else $error("miss changed prio");

   property p_block;
      frm_valid_in && frm_port_in == 3'h0 && s.pctl[0] == 3'h5 &&
         !any_hit |=> res_drop_out && res_valid_out;
   endproperty
   a_block: assert property (p_block) else $error("block no drop");

   property p_repl;
      frm_valid_in && pc_en_now && any_hit &&
         s.tbl[win][0][`ACL_F_MM +: 2] == 2'h3 &&
         s.tbl[win][0][3:0] != 4'h1 |=>
         res_map_out == $past(s.tbl[win][0][`ACL_F_FWD +: 5]);
   endproperty
   a_repl: assert property (p_repl) else $error("map not replaced");

   property p_rd;
      reg_rd_in && reg_addr_in == `ACL_PCTL_BASE |=>
         reg_rdata_out == {29'h0, $past(s.pctl[0])};
   endproperty
   a_rd: assert property (p_rd) else $error("port ctrl read bad");

   property p_us;
      us_t |=> !us_t && s.pre == 10'h000;
   endproperty
   a_us: assert property (p_us) else $error("us tick too fast");

   property p_cnt;
      s.alarm[0] && s.tbl[0][0][3:0] == 4'h1 &&
         s.tbl[0][0][`ACL_F_ALGO] |-> s.cnt[0] == '0;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count not reset");

   c_hit: cover property (frm_valid_in ##1 res_hit_out);
   c_drop: cover property (res_drop_out);
   c_alarm: cover property (|count_alarm_out);
endmodule
`default_nettype wire

// file: acl_rule_filter_engine_test.sv
`timescale 1ns/1ns
`default_nettype none
module acl_rule_filter_engine_test;
   logic clk_in, resetn_in, reg_wr_in, reg_rd_in, frm_valid_in;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, frm_src_ip_in, frm_dst_ip_in;
   logic [31:0] frm_tcp_seq_in, sip, dip;
   logic [2:0] frm_port_in, frm_vlan_prio_in, qos_prio_in, fport;
   logic [47:0] frm_src_mac_in, frm_dst_mac_in, smac;
   logic [15:0] frm_type_in, frm_src_l4_in, frm_dst_l4_in, typ;
   logic [15:0] count_alarm_out;
   logic [7:0] frm_ip_proto_in;
   logic frm_is_tcp_in, frm_is_udp_in, frm_tagged_in;
   logic [5:0] frm_tcp_flags_in;
   logic [4:0] lut_map_in, res_map_out;
   logic res_valid_out, res_drop_out, res_hit_out;
   logic [2:0] res_prio_out, res_vlan_prio_out;
   logic [3:0] res_rule_out;
   int mismatches, cmp_count, cyc;
   localparam logic [47:0] M = 48'h0A1B2C3D4E5F;
   localparam logic [15:0] T = 16'h0800;
   localparam logic [16:0] ALL = 17'h1FFFF;
   localparam logic [16:0] NR = 17'h187FF;
   localparam logic [16:0] DH = 17'h18000;
   localparam logic [16:0] H1 = {2'b01, 4'h1, 5'h04, 3'h1, 3'h1};
   localparam logic [16:0] DR = {2'b10, 15'h0000};

   acl_rule_filter_engine #(.US_CYC(4), .MS_US(3)) DUT (.clk_in, .resetn_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .frm_valid_in, .frm_port_in, .frm_src_mac_in, .frm_dst_mac_in,
      .frm_type_in, .frm_src_ip_in, .frm_dst_ip_in, .frm_ip_proto_in,
      .frm_is_tcp_in, .frm_is_udp_in, .frm_src_l4_in, .frm_dst_l4_in,
      .frm_tcp_seq_in, .frm_tcp_flags_in, .frm_tagged_in, .frm_vlan_prio_in,
      .lut_map_in, .qos_prio_in, .res_valid_out, .res_map_out, .res_prio_out,
      .res_vlan_prio_out, .res_drop_out, .res_hit_out, .res_rule_out,
      .count_alarm_out);
   acl_frame_model pm (.clk_in, .frm_valid_out(frm_valid_in),
      .frm_port_out(frm_port_in), .frm_src_mac_out(frm_src_mac_in),
      .frm_dst_mac_out(frm_dst_mac_in), .frm_type_out(frm_type_in),
      .frm_src_ip_out(frm_src_ip_in), .frm_dst_ip_out(frm_dst_ip_in),
      .frm_ip_proto_out(frm_ip_proto_in), .frm_is_tcp_out(frm_is_tcp_in),
      .frm_is_udp_out(frm_is_udp_in), .frm_src_l4_out(frm_src_l4_in),
      .frm_dst_l4_out(frm_dst_l4_in), .frm_tcp_seq_out(frm_tcp_seq_in),
      .frm_tcp_flags_out(frm_tcp_flags_in), .frm_tagged_out(frm_tagged_in),
      .frm_vlan_prio_out(frm_vlan_prio_in), .lut_map_out(lut_map_in),
      .qos_prio_out(qos_prio_in));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask
   // Counts alarm pulses of entry 0 over c cycles
   task al(input int c, input logic [31:0] e);
      int k;
      k = 0;
      repeat (c) begin
         @(posedge clk_in);
         #1 k = k + count_alarm_out[0];
      end
      chk(k, e);
   endtask
   task rl(input logic [3:0] n, input logic [31:0] a, b, c, d);
      wr({2'h0, n, 2'h0}, a);
      wr({2'h0, n, 2'h1}, b);
      wr({2'h0, n, 2'h2}, c);
      wr({2'h0, n, 2'h3}, d);
   endtask
   function automatic logic [31:0] w0(input logic [1:0] md, ts,
      input logic sd, eq, input logic [1:0] mm, input logic [2:0] rp,
      input logic remark_enable, input logic [2:0] p, input logic [1:0] pmd,
      input logic [4:0] fw);
      return {7'h00, fw, pmd, p, remark_enable, rp, mm, 3'h0, eq, sd, ts, md};
   endfunction
   // Result packed as drop, hit, rule, map, prio, vlan
   task fr(input logic [47:0] dm, input logic [4:0] lut,
      input logic [2:0] q, input logic [16:0] e, m);
      logic [16:0] g;
      pm.send(fport, smac, dm, typ, sip, dip, lut, q);
      #1;
      g = {res_drop_out, res_hit_out, res_rule_out, res_map_out,
         res_prio_out, res_vlan_prio_out};
      chk({14'h0, res_valid_out, g & m}, {14'h0, 1'b1, e & m});
   endtask
   task report_and_stop;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         report_and_stop;
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {resetn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      {mismatches, cmp_count, cyc} = '0;
      fport = 3'h0;
      smac = 48'h111111111111;
      typ = T;
      sip = 32'h0A000001;
      dip = 32'h0A000002;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(8'h40, 32'h0);
      rd(8'h00, 32'h0);
      wr(8'h60, 32'hFFFFFFFF);
      rd(8'h60, 32'h0);
      wr(8'h40, 32'h00000004);
      rd(8'h40, 32'h00000004);
      rl(4'h0, w0(2'h1, 2'h1, 1'b0, 1'b1, 2'h3, 3'h6, 1'b1, 3'h5, 2'h3,
         5'h03), M[31:0], {T, M[47:32]}, 32'h00010000);
      fr(M, 5'h1C, 3'h2, {2'b01, 4'h0, 5'h03, 3'h5, 3'h6}, ALL);
      fr(M ^ 48'h1, 5'h1C, 3'h2, {2'b00, 4'h0, 5'h1C, 3'h2, 3'h1},
         NR);
      smac = M;
      fr(48'h2, 5'h1C, 3'h2, {2'b00, 4'h0, 5'h1C, 3'h2, 3'h1}, NR);
      smac = 48'h111111111111;
      wr(8'h00, w0(2'h1, 2'h1, 1'b0, 1'b0, 2'h3, 3'h6, 1'b1, 3'h5, 2'h3,
         5'h03));
      fr(M ^ 48'h1, 5'h1C, 3'h2, {2'b01, 4'h0, 5'h03, 3'h5, 3'h6},
         ALL);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, w0(2'h1, 2'h1, 1'b0, 1'b1, i[1:0], 3'h0, 1'b0, 3'h4,
            i[1:0], 5'h06));
         fr(M, 5'h0C, 3'h3, {2'b01, 4'h0, (i == 0) ? 5'h0C : (i == 1) ?
            5'h0E : (i == 2) ? 5'h04 : 5'h06, i[0] ? 3'h4 : 3'h3, 3'h1},
            ALL);
      end
      wr(8'h00, 32'h0);
      wr(8'h03, 32'h0);
      rl(4'h3, w0(2'h1, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h08), M[31:0], {T, M[47:32]}, 32'h00180003);
      rl(4'h4, w0(2'h1, 2'h2, 1'b0, 1'b1, 2'h0, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h00), 32'h0, 32'h86DD0000, 32'h0);
      rl(4'h5, w0(2'h1, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h10), M[31:0], {T, M[47:32]}, 32'h00200005);
      rl(4'h9, w0(2'h1, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h10), M[31:0], {T, M[47:32]}, 32'h02000009);
      rl(4'h7, w0(2'h2, 2'h2, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h02), 32'h0, 32'h0, 32'h00800007);
      fr(M, 5'h1F, 3'h1, {2'b01, 4'h5, 5'h10, 3'h1, 3'h1},
         ALL);
      typ = 16'h86DD;
      fr(M, 5'h1F, 3'h1, {2'b01, 4'h3, 5'h08, 3'h1, 3'h1},
         ALL);
      typ = T;
      dip = sip;
      fr(48'h2, 5'h1F, 3'h1, {2'b01, 4'h7, 5'h02, 3'h1, 3'h1}, ALL);
      wr(8'h40, 32'h00000005);
      fr(48'h2, 5'h1F, 3'h1, {2'b01, 4'h7, 5'h02, 3'h1, 3'h1}, ALL);
      dip = 32'h0A000002;
      fr(48'h2, 5'h1F, 3'h1, {2'b10, 15'h0}, DH);
      fr(48'h2, 5'h1F, 3'h1, {2'b10, 15'h0}, DH);
      rl(4'h1, w0(2'h3, 2'h0, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h04), 32'h0, 32'h00000006, 32'h00020001);
      fr(48'h2, 5'h1F, 3'h1, H1, ALL);
      wr(8'h04, w0(2'h3, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h04) | 32'h00000180);
      wr(8'h05, 32'h20001F00);
      wr(8'h06, 32'h00020200);
      fr(48'h2, 5'h1F, 3'h1, H1, ALL);
      wr(8'h06, 32'h00020000);
      fr(48'h2, 5'h1F, 3'h1, DR, DH);
      wr(8'h06, 32'h00020200);
      wr(8'h04, w0(2'h3, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h04) | 32'h000001C0);
      fr(48'h2, 5'h1F, 3'h1, DR, DH);
      rl(4'h1, w0(2'h2, 2'h1, 1'b0, 1'b1, 2'h3, 3'h0, 1'b0, 3'h0, 2'h0,
         5'h04), 32'h0A000000, 32'hFFFFFF00, 32'h00020001);
      fr(48'h2, 5'h1F, 3'h1, H1, ALL);
      wr(8'h00, 32'h00800401);
      fr(M, 5'h1F, 3'h1, H1, ALL);
      chk({16'h0, count_alarm_out}, 32'h0);
      fr(M, 5'h1F, 3'h1, H1, ALL);
      chk({16'h0, count_alarm_out}, 32'h1);
      wr(8'h00, 32'h00000401);
      fr(M, 5'h1F, 3'h1, H1, ALL);
      rd(8'h48, 32'h00010081);
      al(10, 32'h1);
      wr(8'h00, 32'h01000401);
      fr(M, 5'h1F, 3'h1, H1, ALL);
      al(10, 32'h0);
      al(20, 32'h1);
      report_and_stop;
   end
endmodule
`default_nettype wire
